// [logic/iwd_pkg.sv]
/*
 * Types shared by the I/O-port watchdog.
 * Assumes the constants of iwd_regs.svh are included where needed.
 */
package iwd_pkg;

	// One I/O port access as seen in a single clock cycle
	typedef struct packed {
		logic [7:0] addr;
		logic       wr;
		logic       rd;
		logic [7:0] wdata;
	} iwd_io_req_s;

	typedef logic [23:0] iwd_count_t;

endpackage : iwd_pkg

// [logic/iwd_regs.svh]
/*
 * Register offsets, field positions, reset values and timing counts of the
 * I/O-port watchdog.
 * Assumes 8-bit I/O port addresses and a 200 MHz system clock.
 */
`ifndef IWD_REGS_SVH
`define IWD_REGS_SVH

// Port offsets
`define IWD_OFS_CONTROL      8'hA8
`define IWD_OFS_TIMEOUT_LOW  8'hAA
`define IWD_OFS_TIMEOUT_MID  8'hAB
`define IWD_OFS_TIMEOUT_HIGH 8'hAC
`define IWD_OFS_STATUS       8'hAD
`define IWD_OFS_RELOAD       8'hAE

// Field positions
`define IWD_CTRL_ENABLE_BIT  6
`define IWD_STAT_FLAG_BIT    7

// Reset values
`define IWD_RST_ENABLE       1'h0
`define IWD_RST_TIMEOUT      24'h000000
`define IWD_RST_COUNT        24'h000000

// Timing
`define IWD_CLK_PERIOD_NS    5
`define IWD_RST_PULSE_NS     1000
`define IWD_RST_PULSE_CYC    ((`IWD_RST_PULSE_NS + `IWD_CLK_PERIOD_NS - 1) / `IWD_CLK_PERIOD_NS)

`endif

// [logic/iwd_top.sv]
/*
 * Software-retriggered watchdog reached through six byte-wide I/O ports,
 * counting a 32.768 kHz timebase and pulsing a system reset on timeout.
 * Assumes I/O accesses are single-cycle strobes synchronous to clk and
 * the timebase arrives as an asynchronous square wave on a pin.
 */
// Behaviour
// [RULE_01] Control bit 6 enables counting; cleared after reset.
// [RULE_02] Writing one to the enable bit restarts the counter from zero.
// [RULE_03] Enabled counter reaching the timeout value pulses the system reset.
// [RULE_04] Counter is 24 bits and steps once per timebase period.
// [RULE_05] Timeouts from one to 2^24-1 timebase periods are selectable.
// [RULE_06] Timeout value lives in three read-write bytes, low, mid, high.
// [RULE_07] Timeout sets status bit 7; writing one clears it, zero keeps it.
// [RULE_08] Any write to the reload port restarts the counter before timeout.
// [RULE_09] Only software writes retrigger the count; no hardware input does.
// [RULE_10] Software disables, loads the timeout bytes, then enables.
// [RULE_11] Reserved control and status bits read zero and ignore writes.
`include "iwd_regs.svh"

module iwd_top
	import iwd_pkg::*;
(
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rst_n,
	// I/O port access
	input  wire iwd_io_req_s io_req,
	output logic [7:0]       io_rdata,
	// Timebase pin
	input  wire logic        timebase_pin,
	// System reset request and timeout flag
	output logic             sys_reset,
	output logic             timed_out
);

	localparam int unsigned PULSE_CYC = `IWD_RST_PULSE_CYC;

	logic [1:0] rst_sync_r;
	logic       rst_s_n;
	logic [2:0] tb_sync_r;
	logic       tb_lvl_r;
	logic       tick;
	logic       enable_r;
	iwd_count_t timeout_r;
	iwd_count_t count_r;
	iwd_count_t count_inc;
	logic       flag_r;
	logic       sys_reset_r;
	logic [7:0] pulse_cnt_r;
	logic [7:0] io_rdata_r;
	logic       wr_ctrl;
	logic       wr_stat;
	logic       wr_reload;
	logic       restart;
	logic       fire;

	////////////////////////////////////////////////////////////////////////
	// Reset release

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_sync_r <= 2'h0;
		end else begin
			rst_sync_r <= {rst_sync_r[0], 1'h1};
		end
	end
	assign rst_s_n = rst_sync_r[1];

	////////////////////////////////////////////////////////////////////////
	// Timebase sampling; a rising edge counts once stages two and three agree

	always_ff @(posedge clk or negedge rst_s_n) begin
		if (!rst_s_n) begin
			tb_sync_r <= 3'h0;
			tb_lvl_r  <= 1'h0;
		end else begin
			tb_sync_r <= {tb_sync_r[1:0], timebase_pin};
			if (tb_sync_r[1] == tb_sync_r[2]) begin
				tb_lvl_r <= tb_sync_r[2];
			end
		end
	end
	assign tick = tb_sync_r[1] & tb_sync_r[2] & ~tb_lvl_r; // see [RULE_04]

	////////////////////////////////////////////////////////////////////////
	// Write decode

	assign wr_ctrl   = io_req.wr && (io_req.addr == `IWD_OFS_CONTROL);
	assign wr_stat   = io_req.wr && (io_req.addr == `IWD_OFS_STATUS);
	assign wr_reload = io_req.wr && (io_req.addr == `IWD_OFS_RELOAD);
	// Only register writes restart the count, never a pin
	assign restart = (wr_ctrl && io_req.wdata[`IWD_CTRL_ENABLE_BIT]) // see [RULE_02]
		|| (wr_reload && !flag_r); // see [RULE_08] see [RULE_09]

	////////////////////////////////////////////////////////////////////////
	// Control and timeout bytes

	always_ff @(posedge clk or negedge rst_s_n) begin
		if (!rst_s_n) begin
			enable_r <= `IWD_RST_ENABLE;
		end else if (wr_ctrl) begin
			enable_r <= io_req.wdata[`IWD_CTRL_ENABLE_BIT]; // see [RULE_01] see [RULE_11]
		end
	end

	// Byte lanes of the timeout value, one per port
	for (genvar b = 0; b < 3; b++) begin : g_tbyte
		always_ff @(posedge clk or negedge rst_s_n) begin
			if (!rst_s_n) begin
				timeout_r[8*b +: 8] <= 8'(`IWD_RST_TIMEOUT >> (8*b));
			end else if (io_req.wr && io_req.addr == 8'(`IWD_OFS_TIMEOUT_LOW + b)) begin
				timeout_r[8*b +: 8] <= io_req.wdata; // see [RULE_06]
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Counter and timeout

	assign count_inc = count_r + 24'h000001;
	// Counter stops once expired; a value of zero never matches
	// Zero is blocked explicitly, else the wrap to zero would fire
	assign fire = enable_r && !flag_r && tick && !restart && (timeout_r != 24'h000000)
		&& (count_inc == timeout_r); // see [RULE_03] see [RULE_05]

	always_ff @(posedge clk or negedge rst_s_n) begin
		if (!rst_s_n) begin
			count_r <= `IWD_RST_COUNT;
		end else if (restart) begin
			count_r <= 24'h000000; // see [RULE_02] see [RULE_08]
		end else if (enable_r && !flag_r && tick) begin
			count_r <= count_inc; // see [RULE_04]
		end
	end

	// Set wins over a same-cycle clear so no timeout is lost
	always_ff @(posedge clk or negedge rst_s_n) begin
		if (!rst_s_n) begin
			flag_r <= 1'h0;
		end else if (fire) begin
			flag_r <= 1'h1; // see [RULE_07]
		end else if (wr_stat && io_req.wdata[`IWD_STAT_FLAG_BIT]) begin
			flag_r <= 1'h0; // see [RULE_07]
		end
	end

	// Reset pulse long enough for the board reset logic to catch it
	always_ff @(posedge clk or negedge rst_s_n) begin
		if (!rst_s_n) begin
			sys_reset_r <= 1'h0;
			pulse_cnt_r <= 8'h00;
		end else if (fire) begin
			sys_reset_r <= 1'h1; // see [RULE_03]
			pulse_cnt_r <= 8'(PULSE_CYC - 1);
		end else if (pulse_cnt_r != 8'h00) begin
			pulse_cnt_r <= pulse_cnt_r - 8'h01;
		end else begin
			sys_reset_r <= 1'h0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read data

	always_ff @(posedge clk or negedge rst_s_n) begin
		if (!rst_s_n) begin
			io_rdata_r <= 8'h00;
		end else if (io_req.rd) begin
			unique case (io_req.addr)
				`IWD_OFS_CONTROL:      io_rdata_r <= 8'(enable_r) << `IWD_CTRL_ENABLE_BIT; // see [RULE_11]
				`IWD_OFS_TIMEOUT_LOW:  io_rdata_r <= timeout_r[7:0];
				`IWD_OFS_TIMEOUT_MID:  io_rdata_r <= timeout_r[15:8];
				`IWD_OFS_TIMEOUT_HIGH: io_rdata_r <= timeout_r[23:16];
				`IWD_OFS_STATUS:       io_rdata_r <= 8'(flag_r) << `IWD_STAT_FLAG_BIT; // see [RULE_11]
				default:               io_rdata_r <= 8'h00;
			endcase
		end
	end

	assign io_rdata  = io_rdata_r;
	assign sys_reset = sys_reset_r;
	assign timed_out = flag_r;

	////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_s_n);

	property p_enable_write;
		wr_ctrl |=> enable_r == $past(io_req.wdata[`IWD_CTRL_ENABLE_BIT]);
	endproperty
	a_enable_write: assert property (p_enable_write) else $error("enable bit not written"); // see [RULE_01]

	property p_enable_restart;
		wr_ctrl && io_req.wdata[`IWD_CTRL_ENABLE_BIT] |=> count_r == 24'h000000 && enable_r;
	endproperty
	a_enable_restart: assert property (p_enable_restart) else $error("enable did not restart"); // see [RULE_02]

	property p_timeout_fires;
		enable_r && !flag_r && tick && !restart && timeout_r != 24'h000000
			&& count_inc == timeout_r
			|=> sys_reset && timed_out ##1 sys_reset[*3];
	endproperty
	a_timeout_fires: assert property (p_timeout_fires) else $error("timeout missed"); // see [RULE_03]

	property p_count_steps;
		enable_r && !flag_r && tick && !restart |=> count_r == $past(count_inc);
	endproperty
	a_count_steps: assert property (p_count_steps) else $error("counter did not step"); // see [RULE_04]

	property p_count_still;
		!tick && !restart |=> count_r == $past(count_r);
	endproperty
	a_count_still: assert property (p_count_still) else $error("counter moved untriggered"); // see [RULE_09]

	property p_mid_byte;
		io_req.wr && io_req.addr == `IWD_OFS_TIMEOUT_MID |=> timeout_r[15:8] == $past(io_req.wdata);
	endproperty
	a_mid_byte: assert property (p_mid_byte) else $error("mid timeout byte lost"); // see [RULE_06]

	property p_flag_clear;
		wr_stat && io_req.wdata[`IWD_STAT_FLAG_BIT] && !fire |=> !timed_out;
	endproperty
	a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared"); // see [RULE_07]

	property p_flag_keep;
		flag_r && !(wr_stat && io_req.wdata[`IWD_STAT_FLAG_BIT]) |=> timed_out;
	endproperty
	a_flag_keep: assert property (p_flag_keep) else $error("flag dropped"); // see [RULE_07]

	property p_reload;
		wr_reload && !flag_r |=> count_r == 24'h000000;
	endproperty
	a_reload: assert property (p_reload) else $error("reload ignored"); // see [RULE_08]

	property p_reserved_zero;
		io_req.rd && (io_req.addr == `IWD_OFS_CONTROL || io_req.addr == `IWD_OFS_STATUS)
			|=> io_rdata[5:0] == 6'h00;
	endproperty
	a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits set"); // see [RULE_11]

endmodule : iwd_top

// [tb/io_port_watchdog_timer_bench.sv]
/*
 * Self-checking bench for the I/O-port watchdog: register access, timeout,
 * restart by reload and by enable, flag clearing.
 * Assumes the design pulses sys_reset for 200 clocks and steps within a few
 * clocks of each timebase rising edge.
 */
`include "iwd_regs.svh"

module io_port_watchdog_timer_bench
	import iwd_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	iwd_io_req_s req = '0;
	logic [7:0]  io_rdata;
	logic        pin = 1'b0;
	logic        sys_reset;
	logic        timed_out;
	logic [7:0]  rv;
	logic [7:0]  wd;
	logic [31:0] seed = 32'h51DD2AD5;
	logic [23:0] tv;
	int          n;
	int          err_count = 0;
	int          checks = 0;

	iwd_top iwd_top_i (
		.clk          (clk),
		.rst_n        (rst_n),
		.io_req       (req),
		.io_rdata     (io_rdata),
		.timebase_pin (pin),
		.sys_reset    (sys_reset),
		.timed_out    (timed_out)
	);

	always #2.5 clk = ~clk;

	////////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd

	// Only the enable bit survives a control write
	function automatic logic [7:0] exp_ctrl(input logic [7:0] d);
		return d & 8'h40;
	endfunction : exp_ctrl

	task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
		checks++;
		if (seen !== exp) begin
			err_count++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	task automatic io(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge clk) req <= '{addr: a, wr: w, rd: !w, wdata: d};
		@(posedge clk) req <= '0;
		@(posedge clk) #1 rv = io_rdata;
	endtask : io

	// Full timebase periods, far slower than the synchroniser
	task automatic tick(input int k);
		repeat (k) begin
			@(posedge clk) pin <= 1'b1;
			repeat (8) @(posedge clk);
			pin <= 1'b0;
			repeat (7) @(posedge clk);
		end
		#1;
	endtask : tick

	task automatic prog(input logic [23:0] v);
		io(1'b1, 8'hA8, 8'h00);
		io(1'b1, 8'hAA, v[7:0]);
		io(1'b1, 8'hAB, v[15:8]);
		io(1'b1, 8'hAC, v[23:16]);
		io(1'b1, 8'hA8, 8'h40);
	endtask : prog

	task automatic finish_test();
		$display("checks %0d errors %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : finish_test

	////////////////////////////////////////////////////////////////////////////
	initial begin
		#200000;
		err_count++;
		finish_test();
	end

	initial begin
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		io(1'b0, 8'hA8, 8'h00);
		chk(rv, 8'h00);
		io(1'b0, 8'hAC, 8'h00);
		chk(rv, 8'h00);
		io(1'b0, 8'hAD, 8'h00);
		chk(rv, 8'h00);
		for (int i = 0; i < 8; i++) begin
			tv = 24'(rnd());
			prog(tv);
			io(1'b0, 8'hAA, 8'h00);
			chk(rv, tv[7:0]);
			io(1'b0, 8'hAB, 8'h00);
			chk(rv, tv[15:8]);
			io(1'b0, 8'hAC, 8'h00);
			chk(rv, tv[23:16]);
			// Written byte kept apart, the read overwrites rv
			wd = 8'(rnd());
			io(1'b1, 8'hA8, wd);
			io(1'b0, 8'hA8, 8'h00);
			chk(rv, exp_ctrl(wd));
			io(1'b1, 8'hAD, 8'(rnd()) & 8'h7F);
			io(1'b0, 8'hAD, 8'h00);
			chk(rv, 8'h00);
		end
		// Timeout after exactly n periods
		n = 2 + int'(rnd() % 3);
		prog(24'(n));
		tick(n - 1);
		chk(timed_out, 1'b0);
		tick(1);
		chk({sys_reset, timed_out}, 2'b11);
		io(1'b0, 8'hAD, 8'h00);
		chk(rv, 8'h80);
		io(1'b1, 8'hAE, 8'(rnd())); // flagged: reload has no effect
		io(1'b1, 8'hAD, 8'h7F);
		chk(timed_out, 1'b1);
		repeat (150) @(posedge clk);
		#1 chk(sys_reset, 1'b1);
		repeat (60) @(posedge clk);
		#1 chk(sys_reset, 1'b0);
		io(1'b1, 8'hAD, 8'h80);
		chk(timed_out, 1'b0);
		// Restarts by reload and by enable write
		io(1'b1, 8'hA8, 8'h40);
		tick(n - 1);
		io(1'b1, 8'hAE, 8'(rnd()));
		tick(n - 1);
		chk(timed_out, 1'b0);
		tick(1);
		chk(timed_out, 1'b1);
		io(1'b1, 8'hAD, 8'hFF);
		io(1'b1, 8'hA8, 8'hC0);
		tick(n - 1);
		io(1'b1, 8'hA8, 8'h40);
		tick(n - 1);
		chk(timed_out, 1'b0);
		tick(1);
		chk(timed_out, 1'b1);
		// Disabled: timebase alone never fires
		io(1'b1, 8'hAD, 8'h80);
		io(1'b1, 8'hA8, 8'h00);
		tick(n + 2);
		chk(timed_out, 1'b0);
		finish_test();
	end

endmodule : io_port_watchdog_timer_bench
